// [core/line_timing_config_regs.v]
// line timing configuration registers with sync and restore pulses
//
// Behaviour
// - sync pulse start, 10 bits at 0x0C/0x0D
// - sync pulse end, 10 bits at 0x0E/0x0F
// - upper bits 15-10 ignore writes, read zero
// - start delay resets to 0x3B and 0x03
// - end delay resets to 0x20 and 0x00
// - loop filter adjust at 0x10, reset 0x00
// - detect window at 0x11, reset 0xDD
// - sync outside window counted as missing
// - restore gate start 0x12/0x13, reset 0x3F
// - restore gate end 0x14/0x15, reset 0x52
// - sync output driven only when enable set
`timescale 1ns/1ps
`include "line_timing_regs.vh"
module line_timing_config_regs #(
  parameter POS_WIDTH = 10,
  parameter CNT_WIDTH = 8
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset,
  // sub-address register port
  input  wire [7:0]           reg_addr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata_q,
  output reg                  reg_rvalid_q,
  // line-lock timing inputs
  input  wire                 line_start,
  input  wire                 pixel_en,
  input  wire                 sync_detect,
  input  wire                 output_drive_enable,
  // horizontal sync pin, active low
  output reg                  hsync_n_out_q,
  output reg                  hsync_n_oe_n_q,
  // internal timing outputs
  output reg                  black_level_restore_gate_q,
  output reg  [7:0]           pll_loop_filter_adjust_q,
  output reg  [7:0]           sync_window_q,
  output reg                  missing_sync_q,
  output reg  [CNT_WIDTH-1:0] missing_sync_count_q
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  reg [7:0]           sync_out_start_low_q;
  reg [1:0]           sync_out_start_high_q;
  reg [7:0]           sync_out_end_low_q;
  reg [1:0]           sync_out_end_high_q;
  reg [7:0]           restore_gate_start_low_q;
  reg [1:0]           restore_gate_start_high_q;
  reg [7:0]           restore_gate_end_low_q;
  reg [1:0]           restore_gate_end_high_q;

  // ---------------------------------------------------------------
  // working copies and line position
  // ---------------------------------------------------------------
  reg [POS_WIDTH-1:0] sync_start_act_q;
  reg [POS_WIDTH-1:0] sync_end_act_q;
  reg [POS_WIDTH-1:0] gate_start_act_q;
  reg [POS_WIDTH-1:0] gate_end_act_q;
  reg [POS_WIDTH-1:0] position_q;
  reg                 position_valid_q;
  reg [7:0]           read_d;

  wire                hsync_pulse;
  wire                gate_pulse;

  // joins a low byte and the two upper bits into one value
  function [POS_WIDTH-1:0] join10;
    input [7:0] low;
    input [1:0] high;
    begin
      join10 = {high, low};
    end
  endfunction

  // presents two upper bits in a byte with unused bits zero
  function [7:0] high_byte;
    input [1:0] high;
    begin
      high_byte = {{`HIGH_UNUSED_WIDTH{1'b0}}, high};
    end
  endfunction

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // byte writes by sub-address
  always @(posedge core_clk) begin
    if (reset) begin
      sync_out_start_low_q      <= `SYNC_OUT_START_LOW_RST;
      sync_out_start_high_q     <= `SYNC_OUT_START_HIGH_RST;
      sync_out_end_low_q        <= `SYNC_OUT_END_LOW_RST;
      sync_out_end_high_q       <= `SYNC_OUT_END_HIGH_RST;
      pll_loop_filter_adjust_q  <= `PLL_LOOP_FILTER_ADJUST_RST;
      sync_window_q             <= `SYNC_DETECT_WINDOW_RST;
      restore_gate_start_low_q  <= `RESTORE_GATE_START_LOW_RST;
      restore_gate_start_high_q <= `RESTORE_GATE_START_HIGH_RST;
      restore_gate_end_low_q    <= `RESTORE_GATE_END_LOW_RST;
      restore_gate_end_high_q   <= `RESTORE_GATE_END_HIGH_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SYNC_OUT_START_LOW_ADDR: begin
          sync_out_start_low_q <= reg_wdata;
        end
        `SYNC_OUT_START_HIGH_ADDR: begin
          sync_out_start_high_q <=
            reg_wdata[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
        end
        `SYNC_OUT_END_LOW_ADDR: begin
          sync_out_end_low_q <= reg_wdata;
        end
        `SYNC_OUT_END_HIGH_ADDR: begin
          sync_out_end_high_q <=
            reg_wdata[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
        end
        `PLL_LOOP_FILTER_ADJUST_ADDR: begin
          pll_loop_filter_adjust_q <= reg_wdata;
        end
        `SYNC_DETECT_WINDOW_ADDR: begin
          sync_window_q <= reg_wdata;
        end
        `RESTORE_GATE_START_LOW_ADDR: begin
          restore_gate_start_low_q <= reg_wdata;
        end
        `RESTORE_GATE_START_HIGH_ADDR: begin
          restore_gate_start_high_q <=
            reg_wdata[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
        end
        `RESTORE_GATE_END_LOW_ADDR: begin
          restore_gate_end_low_q <= reg_wdata;
        end
        `RESTORE_GATE_END_HIGH_ADDR: begin
          restore_gate_end_high_q <=
            reg_wdata[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // read multiplexer, unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `SYNC_OUT_START_LOW_ADDR:      read_d = sync_out_start_low_q;
      `SYNC_OUT_START_HIGH_ADDR:     read_d =
        high_byte(sync_out_start_high_q);
      `SYNC_OUT_END_LOW_ADDR:        read_d = sync_out_end_low_q;
      `SYNC_OUT_END_HIGH_ADDR:       read_d =
        high_byte(sync_out_end_high_q);
      `PLL_LOOP_FILTER_ADJUST_ADDR:  read_d = pll_loop_filter_adjust_q;
      `SYNC_DETECT_WINDOW_ADDR:      read_d = sync_window_q;
      `RESTORE_GATE_START_LOW_ADDR:  read_d = restore_gate_start_low_q;
      `RESTORE_GATE_START_HIGH_ADDR: read_d =
        high_byte(restore_gate_start_high_q);
      `RESTORE_GATE_END_LOW_ADDR:    read_d = restore_gate_end_low_q;
      `RESTORE_GATE_END_HIGH_ADDR:   read_d =
        high_byte(restore_gate_end_high_q);
      default:                       read_d = `UNMAPPED_READ_VALUE;
    endcase
  end

  // read data held until the next read
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= read_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // working copies and horizontal position
  // ---------------------------------------------------------------
  // load whole values at line start
  // a byte written mid-line waits for the next line boundary
  always @(posedge core_clk) begin
    if (reset) begin
      sync_start_act_q <= join10(`SYNC_OUT_START_LOW_RST,
                                 `SYNC_OUT_START_HIGH_RST);
      sync_end_act_q   <= join10(`SYNC_OUT_END_LOW_RST,
                                 `SYNC_OUT_END_HIGH_RST);
      gate_start_act_q <= join10(`RESTORE_GATE_START_LOW_RST,
                                 `RESTORE_GATE_START_HIGH_RST);
      gate_end_act_q   <= join10(`RESTORE_GATE_END_LOW_RST,
                                 `RESTORE_GATE_END_HIGH_RST);
    end else if (line_start) begin
      sync_start_act_q <= join10(sync_out_start_low_q,
                                 sync_out_start_high_q);
      sync_end_act_q   <= join10(sync_out_end_low_q,
                                 sync_out_end_high_q);
      gate_start_act_q <= join10(restore_gate_start_low_q,
                                 restore_gate_start_high_q);
      gate_end_act_q   <= join10(restore_gate_end_low_q,
                                 restore_gate_end_high_q);
    end
  end

  // position counter locked to line start
  // counter holds at its top so it never wraps within a line
  always @(posedge core_clk) begin
    if (reset) begin
      position_q       <= {POS_WIDTH{1'b0}};
      position_valid_q <= 1'b0;
    end else if (line_start) begin
      position_q       <= {POS_WIDTH{1'b0}};
      position_valid_q <= 1'b1;
    end else if (pixel_en && position_q != {POS_WIDTH{1'b1}}) begin
      position_q       <= position_q + 1'b1;
      position_valid_q <= 1'b1;
    end else begin
      position_valid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // timed pulses
  // ---------------------------------------------------------------
  timed_pulse #(
    .POS_WIDTH      (POS_WIDTH)
  ) u_sync_pulse (
    .core_clk       (core_clk),
    .reset          (reset),
    .position       (position_q),
    .position_valid (position_valid_q),
    .start_value    (sync_start_act_q),
    .end_value      (sync_end_act_q),
    .pulse_q        (hsync_pulse)
  );

  timed_pulse #(
    .POS_WIDTH      (POS_WIDTH)
  ) u_gate_pulse (
    .core_clk       (core_clk),
    .reset          (reset),
    .position       (position_q),
    .position_valid (position_valid_q),
    .start_value    (gate_start_act_q),
    .end_value      (gate_end_act_q),
    .pulse_q        (gate_pulse)
  );

  // ---------------------------------------------------------------
  // outputs and missing sync detection
  // ---------------------------------------------------------------
  // pin drive, restore gate and missing sync count
  always @(posedge core_clk) begin
    if (reset) begin
      hsync_n_out_q              <= 1'b1;
      hsync_n_oe_n_q             <= 1'b1;
      black_level_restore_gate_q <= 1'b0;
      missing_sync_q             <= 1'b0;
      missing_sync_count_q       <= {CNT_WIDTH{1'b0}};
    end else begin
      hsync_n_out_q              <= ~hsync_pulse;
      // pin released while enable is low
      hsync_n_oe_n_q             <= ~output_drive_enable;
      black_level_restore_gate_q <= gate_pulse;
      missing_sync_q <= sync_detect &&
                        (position_q >= {2'b00, sync_window_q});
      if (sync_detect && position_q >= {2'b00, sync_window_q}) begin
        if (missing_sync_count_q != {CNT_WIDTH{1'b1}}) begin
          missing_sync_count_q <= missing_sync_count_q + 1'b1;
        end
      end else if (sync_detect) begin
        missing_sync_count_q <= {CNT_WIDTH{1'b0}};
      end
    end
  end

endmodule

// [core/timed_pulse.v]
// one timed pulse set and cleared by horizontal position compare
`timescale 1ns/1ps
module timed_pulse #(
  parameter POS_WIDTH = 10
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset,
  // position and programmed edges
  input  wire [POS_WIDTH-1:0] position,
  input  wire                 position_valid,
  input  wire [POS_WIDTH-1:0] start_value,
  input  wire [POS_WIDTH-1:0] end_value,
  // pulse
  output reg                  pulse_q
);

  reg pulse_d;

  // compare against start and end
  // end wins when both match so a zero-width pulse stays low
  always @* begin
    pulse_d = pulse_q;
    if (position_valid) begin
      if (position == end_value) begin
        pulse_d = 1'b0;
      end else if (position == start_value) begin
        pulse_d = 1'b1;
      end
    end
  end

  // pulse flop
  always @(posedge core_clk) begin
    if (reset) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

endmodule

// [pkg/line_timing_regs.vh]
// offsets, reset values and field layout of the line timing registers
`ifndef LINE_TIMING_REGS_VH
`define LINE_TIMING_REGS_VH

// ---------------------------------------------------------------
// sub-addresses
// ---------------------------------------------------------------
`define SYNC_OUT_START_LOW_ADDR       8'h0C
`define SYNC_OUT_START_HIGH_ADDR      8'h0D
`define SYNC_OUT_END_LOW_ADDR         8'h0E
`define SYNC_OUT_END_HIGH_ADDR        8'h0F
`define PLL_LOOP_FILTER_ADJUST_ADDR   8'h10
`define SYNC_DETECT_WINDOW_ADDR       8'h11
`define RESTORE_GATE_START_LOW_ADDR   8'h12
`define RESTORE_GATE_START_HIGH_ADDR  8'h13
`define RESTORE_GATE_END_LOW_ADDR     8'h14
`define RESTORE_GATE_END_HIGH_ADDR    8'h15

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SYNC_OUT_START_LOW_RST        8'h3B
`define SYNC_OUT_START_HIGH_RST       2'h3
`define SYNC_OUT_END_LOW_RST          8'h20
`define SYNC_OUT_END_HIGH_RST         2'h0
`define PLL_LOOP_FILTER_ADJUST_RST    8'h00
`define SYNC_DETECT_WINDOW_RST        8'hDD
`define RESTORE_GATE_START_LOW_RST    8'h3F
`define RESTORE_GATE_START_HIGH_RST   2'h0
`define RESTORE_GATE_END_LOW_RST      8'h52
`define RESTORE_GATE_END_HIGH_RST     2'h0

// ---------------------------------------------------------------
// field layout of the upper-byte registers
// ---------------------------------------------------------------
`define HIGH_FIELD_MSB                1
`define HIGH_FIELD_LSB                0
`define HIGH_UNUSED_WIDTH             6
`define UNMAPPED_READ_VALUE           8'h00

`endif

// [tb/line_timing_config_regs_properties.sv]
// port assertions for the line timing configuration registers
`timescale 1ns/1ps
module line_timing_config_regs_properties #(
  parameter POS_WIDTH = 10,
  parameter CNT_WIDTH = 8
) (
  // clock and reset
  input wire                 core_clk,
  input wire                 reset,
  // register port
  input wire [7:0]           reg_addr,
  input wire [7:0]           reg_wdata,
  input wire                 reg_wr,
  input wire                 reg_rd,
  input wire [7:0]           reg_rdata_q,
  input wire                 reg_rvalid_q,
  // timing and outputs
  input wire                 line_start,
  input wire                 pixel_en,
  input wire                 sync_detect,
  input wire                 output_drive_enable,
  input wire                 hsync_n_out_q,
  input wire                 hsync_n_oe_n_q,
  input wire                 black_level_restore_gate_q,
  input wire [7:0]           pll_loop_filter_adjust_q,
  input wire [7:0]           sync_window_q,
  input wire                 missing_sync_q,
  input wire [CNT_WIDTH-1:0] missing_sync_count_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  property p_read_answer;
    reg_rd |=> reg_rvalid_q;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read got no answer");
  property p_read_pulse;
    !reg_rd |=> !reg_rvalid_q;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read valid without read");
  property p_high_zero;
    reg_rd && reg_addr inside {8'h0D, 8'h0F, 8'h13, 8'h15}
      |=> reg_rdata_q[7:2] == 6'h00;
  endproperty
  a_high_zero: assert property (p_high_zero)
    else $error("unused upper bits read nonzero");
  property p_unmapped;
    reg_rd && reg_addr > 8'h15 |=> reg_rdata_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read nonzero");
  property p_filter_write;
    reg_wr && reg_addr == 8'h10
      |=> pll_loop_filter_adjust_q == $past(reg_wdata);
  endproperty
  a_filter_write: assert property (p_filter_write)
    else $error("loop filter write lost");
  property p_filter_hold;
    !(reg_wr && reg_addr == 8'h10) |=> $stable(pll_loop_filter_adjust_q);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("loop filter changed unwritten");
  property p_window_write;
    reg_wr && reg_addr == 8'h11 |=> sync_window_q == $past(reg_wdata);
  endproperty
  a_window_write: assert property (p_window_write)
    else $error("detect window write lost");

  // ---------------------------------------------------------------
  // pin drive and missing sync
  // ---------------------------------------------------------------
  property p_drive_enable;
    1'b1 |=> hsync_n_oe_n_q == !$past(output_drive_enable);
  endproperty
  a_drive_enable: assert property (p_drive_enable)
    else $error("sync pin enable wrong");
  property p_missing_cause;
    missing_sync_q |-> $past(sync_detect);
  endproperty
  a_missing_cause: assert property (p_missing_cause)
    else $error("missing flagged without sync");
  property p_count_step;
    missing_sync_q && $past(missing_sync_count_q) != {CNT_WIDTH{1'b1}}
      |-> missing_sync_count_q == $past(missing_sync_count_q) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("missing count did not step");

  // main scenarios reached
  c_read: cover property (reg_rvalid_q);
  c_missing: cover property (missing_sync_q);
  c_sync: cover property (!hsync_n_out_q);
  c_gate: cover property (black_level_restore_gate_q);
endmodule

bind line_timing_config_regs line_timing_config_regs_properties #(
  .POS_WIDTH(POS_WIDTH), .CNT_WIDTH(CNT_WIDTH)
) u_props (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .line_start(line_start), .pixel_en(pixel_en), .sync_detect(sync_detect),
  .output_drive_enable(output_drive_enable),
  .hsync_n_out_q(hsync_n_out_q), .hsync_n_oe_n_q(hsync_n_oe_n_q),
  .black_level_restore_gate_q(black_level_restore_gate_q),
  .pll_loop_filter_adjust_q(pll_loop_filter_adjust_q),
  .sync_window_q(sync_window_q), .missing_sync_q(missing_sync_q),
  .missing_sync_count_q(missing_sync_count_q)
);

// [tb/line_timing_config_regs_tb.sv]
// self-checking bench for the line timing configuration registers
`timescale 1ns/1ps
module line_timing_config_regs_tb;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       line_start = 1'b0;
  logic       pixel_en = 1'b0;
  logic       sync_detect = 1'b0;
  logic       output_drive_enable = 1'b0;
  wire  [7:0] rdata;
  wire  [7:0] pll_q;
  wire  [7:0] window_q;
  wire  [7:0] count_q;
  wire        rvalid;
  wire        hsync_n;
  wire        oe_n;
  wire        gate_q;
  wire        missing_q;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     k;

  line_timing_config_regs DUT (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .line_start(line_start),
    .pixel_en(pixel_en), .sync_detect(sync_detect),
    .output_drive_enable(output_drive_enable), .hsync_n_out_q(hsync_n),
    .hsync_n_oe_n_q(oe_n), .black_level_restore_gate_q(gate_q),
    .pll_loop_filter_adjust_q(pll_q), .sync_window_q(window_q),
    .missing_sync_q(missing_q), .missing_sync_count_q(count_q)
  );

  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // compares one value and counts a mismatch
  task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // one byte write, strobe high for one edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
    end
  endtask

  // one byte read, answer judged one edge later
  task rd(input logic [7:0] a, input logic [7:0] exp);
    begin
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check("rvalid", rvalid, 1'b1);
      check("rdata", rdata, exp);
    end
  endtask

  // reset state of outputs and every register
  task t_reset_values;
    begin
      check("sync pin", hsync_n, 1'b1);
      check("sync enable", oe_n, 1'b1);
      check("count", count_q, 8'h00);
      check("filter out", pll_q, 8'h00);
      check("window out", window_q, 8'hDD);
      rd(8'h0C, 8'h3B);
      rd(8'h0D, 8'h03);
      rd(8'h0E, 8'h20);
      rd(8'h0F, 8'h00);
      rd(8'h10, 8'h00);
      rd(8'h11, 8'hDD);
      rd(8'h12, 8'h3F);
      rd(8'h13, 8'h00);
      rd(8'h14, 8'h52);
      rd(8'h15, 8'h00);
    end
  endtask

  // unused upper bits, unmapped place, control bytes
  task t_byte_access;
    begin
      wr(8'h0D, 8'hFF);
      rd(8'h0D, 8'h03);
      wr(8'h15, 8'hFE);
      rd(8'h15, 8'h02);
      rd(8'h30, 8'h00);
      wr(8'h10, 8'h20);
      rd(8'h10, 8'h20);
      check("filter out", pll_q, 8'h20);
      wr(8'h11, 8'h04);
      rd(8'h11, 8'h04);
      check("window out", window_q, 8'h04);
    end
  endtask

  // sync 5..8 and gate 3..6, start byte rewritten mid-line
  task t_line;
    begin
      wr(8'h0C, 8'h05);
      wr(8'h0D, 8'h00);
      wr(8'h0E, 8'h08);
      wr(8'h0F, 8'h00);
      wr(8'h12, 8'h03);
      wr(8'h13, 8'h00);
      wr(8'h14, 8'h06);
      wr(8'h15, 8'h00);
      output_drive_enable = 1'b1;
      @(negedge core_clk);
      line_start = 1'b1;
      @(negedge core_clk);
      line_start = 1'b0;
      pixel_en = 1'b1;
      reg_addr = 8'h0C;
      reg_wdata = 8'h01;
      for (k = 1; k <= 12; k = k + 1) begin
        @(negedge core_clk);
        reg_wr = (k == 3);
        check("sync pin", hsync_n, !(k >= 7 && k < 10));
        check("gate", gate_q, (k >= 5 && k < 8));
        check("sync enable", oe_n, 1'b0);
      end
      pixel_en = 1'b0;
      output_drive_enable = 1'b0;
      @(negedge core_clk);
      @(negedge core_clk);
      check("sync enable", oe_n, 1'b1);
    end
  endtask

  // new line, advance pos steps, then one sync pulse
  task sync_at(input integer pos, input logic m, input logic [7:0] c);
    begin
      @(negedge core_clk);
      line_start = 1'b1;
      @(negedge core_clk);
      line_start = 1'b0;
      pixel_en = 1'b1;
      repeat (pos) @(negedge core_clk);
      pixel_en = 1'b0;
      sync_detect = 1'b1;
      @(negedge core_clk);
      sync_detect = 1'b0;
      check("missing", missing_q, m);
      check("count", count_q, c);
    end
  endtask

  // window of 4: inside, two outside, inside again
  task t_missing;
    begin
      sync_at(2, 1'b0, 8'h00);
      sync_at(4, 1'b1, 8'h01);
      sync_at(9, 1'b1, 8'h02);
      sync_at(3, 1'b0, 8'h00);
    end
  endtask

  // counts, verdict and end of run
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    t_reset_values;
    t_byte_access;
    t_line;
    t_missing;
    final_report;
  end

  // hang guard
  initial begin
    #200000;
    errors = errors + 1;
    final_report;
  end
endmodule
